// [core/scos_select.sv]
// Six channel output select: serial frame decoder, registers and stage drive.
// Functional notes
// - Reset low forces all six stages off.
// - Mode bit 1 selects pin, 0 serial.
// - Serial state bit is active low.
// - Polarity pin sets parallel input active level.
// - Mode bits for channels 6..1 at 7..2.
// - Serial bits for channels 6..1 at 7..2.
// - Bits 1..0 of both registers read high.
// - Channel 4 status in diag byte bits 7..6.
// - Instruction starts 10; five command codes decoded.
// - Data accepted only after exactly sixteen pulses.
// - Chip select rise commits received data.
// - Reset clears shift register, outputs off.
`timescale 1ns/100ps
`default_nettype none

module scos_select
(
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic reset_n,
	// Serial link from the controller.
	input wire logic chip_select_n,
	input wire logic serial_clk,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_oe,
	// Parallel control pins.
	input wire logic [5:0] parallel_channel_input,
	input wire logic input_polarity_select,
	// Status of stages 4..1, two bits each, 1 means healthy.
	input wire logic [7:0] stage_diag_status,
	// Power stage drive, 1 means on.
	output logic [5:0] power_stage_output
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Written register value with the two unused bits forced high.
	function automatic logic [7:0] fill_unused(input logic [7:0] d);
		fill_unused = {d[7:2], scos_pkg::UNUSED_FILL};
	endfunction

	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	logic [2:0] cs_meta_ff, cs_sync_ff;
	logic cs_prev_ff, sclk_prev_ff;
	logic [5:0] par_meta_ff, par_sync_ff;
	logic pol_meta_ff, pol_sync_ff;
	logic [7:0] diag_meta_ff, diag_sync_ff;
	wire logic cs_active, sclk_s, si_s, cs_fall, cs_rise, sclk_fall, sclk_rise;

	// All pins except clock and reset cross through two flops; only the second stage is read.
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cs_meta_ff <= 3'h4; // Idle: deselected with the link clock low.
			cs_sync_ff <= 3'h4; // Matches cs_prev_ff, so no false edge after reset.
			par_meta_ff <= 6'h00;
			par_sync_ff <= 6'h00;
			pol_meta_ff <= 1'b0;
			pol_sync_ff <= 1'b0;
			diag_meta_ff <= scos_pkg::REG_RESET;
			diag_sync_ff <= scos_pkg::REG_RESET;
		end
		else
		begin
			cs_meta_ff <= {chip_select_n, serial_clk, serial_in};
			cs_sync_ff <= cs_meta_ff;
			par_meta_ff <= parallel_channel_input;
			par_sync_ff <= par_meta_ff;
			pol_meta_ff <= input_polarity_select;
			pol_sync_ff <= pol_meta_ff;
			diag_meta_ff <= stage_diag_status;
			diag_sync_ff <= diag_meta_ff;
		end
	end

	assign cs_active = !cs_sync_ff[2];
	assign sclk_s = cs_sync_ff[1];
	assign si_s = cs_sync_ff[0];

	// Edge history; clock edges count only while the device is selected.
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cs_prev_ff <= 1'b1;
			sclk_prev_ff <= 1'b0;
		end
		else
		begin
			cs_prev_ff <= cs_sync_ff[2];
			sclk_prev_ff <= sclk_s;
		end
	end

	assign cs_fall = cs_prev_ff && cs_active;
	assign cs_rise = !cs_prev_ff && !cs_active;
	assign sclk_fall = cs_active && sclk_prev_ff && !sclk_s;
	assign sclk_rise = cs_active && !sclk_prev_ff && sclk_s;

	// ----------------------------------------------------------------
	// Receive shift register and pulse counter
	// ----------------------------------------------------------------
	logic [15:0] shift_ff;
	logic [4:0] count_ff;
	logic addressed_ff;
	logic [7:0] reply_ff;
	logic [7:0] mode_ff, serial_ff, diag_low_ff;
	wire logic [15:0] nxt_shift;
	wire logic [5:0] cmd;
	wire logic frame_ok;

	assign nxt_shift = {shift_ff[14:0], si_s};
	assign cmd = shift_ff[15:10];
	assign frame_ok = addressed_ff && (count_ff == scos_pkg::FRAME_PULSES);

	// Data enters MSB first on falling serial clock edges.
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			shift_ff <= 16'h0000;
			count_ff <= 5'h00;
		end
		else if (cs_fall)
		begin
			shift_ff <= 16'h0000;
			count_ff <= 5'h00;
		end
		else if (sclk_fall)
		begin
			shift_ff <= nxt_shift;
			// Saturate so an overlong frame never wraps back to sixteen.
			if (count_ff != scos_pkg::COUNT_MAX)
				count_ff <= count_ff + 5'h01;
		end
	end

	// Address check after two bits; the answer byte is fixed after eight.
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			addressed_ff <= 1'b0;
			reply_ff <= scos_pkg::REG_RESET;
		end
		else if (cs_fall || cs_rise)
		begin
			addressed_ff <= 1'b0;
		end
		else if (sclk_fall && count_ff == scos_pkg::ADDR_DONE - 5'h01)
		begin
			addressed_ff <= (nxt_shift[1:0] == scos_pkg::ADDR_PREFIX);
		end
		else if (sclk_fall && count_ff == scos_pkg::CMD_DONE - 5'h01)
		begin
			unique case (nxt_shift[7:2])
				scos_pkg::CMD_READ_MODE: reply_ff <= mode_ff;
				scos_pkg::CMD_READ_SERIAL: reply_ff <= serial_ff;
				default: reply_ff <= diag_low_ff;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Serial output
	// ----------------------------------------------------------------
	// New bits appear on rising edges; the two address bits stay undriven.
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			serial_out <= 1'b1;
			serial_out_oe <= 1'b0;
		end
		else if (!cs_active)
		begin
			serial_out_oe <= 1'b0;
		end
		else if (sclk_rise && count_ff < scos_pkg::FRAME_PULSES)
		begin
			serial_out_oe <= addressed_ff;
			serial_out <= count_ff[3] ? reply_ff[3'(5'h0f - count_ff)]
				: scos_pkg::FIRST_REPLY[3'(5'h07 - count_ff)];
		end
	end

	// ----------------------------------------------------------------
	// Registers, committed on chip select rise
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mode_ff <= scos_pkg::REG_RESET;
			serial_ff <= scos_pkg::REG_RESET;
		end
		else if (cs_rise && frame_ok)
		begin
			if (cmd == scos_pkg::CMD_WRITE_MODE)
				mode_ff <= fill_unused(shift_ff[7:0]);
			if (cmd == scos_pkg::CMD_WRITE_SERIAL)
			begin
				serial_ff <= fill_unused(shift_ff[7:0]);
			end
		end
	end

	// Faults stick until a counted diag read; the clear reloads live status
	// so a fault present in the clearing cycle is never lost.
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			diag_low_ff <= scos_pkg::REG_RESET;
		end
		else if (cs_rise && frame_ok && cmd == scos_pkg::CMD_READ_DIAG)
		begin
			diag_low_ff <= diag_sync_ff;
		end
		else
		begin
			diag_low_ff <= diag_low_ff & diag_sync_ff;
		end
	end

	// ----------------------------------------------------------------
	// Stage drive
	// ----------------------------------------------------------------
	// Outputs follow the registers, so new states act at chip select rise.
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			power_stage_output <= 6'h00;
		end
		else
		begin
			for (int i = 0; i < scos_pkg::CHANNELS; i++)
			begin
				if (mode_ff[scos_pkg::CH_LSB + i])
				begin
					power_stage_output[i] <= pol_sync_ff ~^ par_sync_ff[i];
				end
				else
				begin
					power_stage_output[i] <= !serial_ff[scos_pkg::CH_LSB + i];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	a_reset_all_off: assert property (@(posedge ref_clk) disable iff (1'b0)
		!reset_n |-> power_stage_output == 6'h00 && shift_ff == 16'h0000)
		else $error("stage on or shift data during reset");
	a_serial_drive: assert property (!mode_ff[2] |=>
		power_stage_output[0] == !$past(serial_ff[2]))
		else $error("serial channel drive wrong");
	a_parallel_drive: assert property (mode_ff[7] |=>
		power_stage_output[5] == ($past(pol_sync_ff) ~^ $past(par_sync_ff[5])))
		else $error("parallel channel drive wrong");
	a_mode_write: assert property (cs_rise && frame_ok && cmd == scos_pkg::CMD_WRITE_MODE
		|=> mode_ff == {$past(shift_ff[7:2]), 2'h3})
		else $error("mode register not written");
	a_serial_write: assert property (cs_rise && frame_ok && cmd == scos_pkg::CMD_WRITE_SERIAL
		|=> serial_ff == {$past(shift_ff[7:2]), 2'h3})
		else $error("serial register not written");
	a_unused_high: assert property (mode_ff[1:0] == 2'h3 && serial_ff[1:0] == 2'h3)
		else $error("unused register bits not high");
	a_count_guard: assert property (cs_rise && count_ff != 5'h10
		|=> $stable(mode_ff) && $stable(serial_ff))
		else $error("register changed on bad pulse count");
	a_commit_only_rise: assert property (!cs_rise |=> $stable(mode_ff) && $stable(serial_ff))
		else $error("register changed outside chip select rise");
	a_diag_sticky: assert property (!diag_sync_ff[7] |=> !diag_low_ff[7])
		else $error("channel 4 fault not latched");
	a_addr_silent: assert property (count_ff < 5'h02 || !addressed_ff |-> ##1 !serial_out_oe
		|| $past(addressed_ff))
		else $error("serial output driven without address");
	c_mode_write: cover property (cs_rise && frame_ok && cmd == scos_pkg::CMD_WRITE_MODE);
	c_diag_read: cover property (cs_rise && frame_ok && cmd == scos_pkg::CMD_READ_DIAG);
	c_bad_count: cover property (cs_rise && addressed_ff && count_ff != 5'h10);
endmodule

`default_nettype wire

// [core/scos_pkg.sv]
// Constants shared by the six channel output select block.
package scos_pkg;

	// ----------------------------------------------------------------
	// Frame geometry
	// ----------------------------------------------------------------
	localparam int unsigned CHANNELS = 6;
	localparam int unsigned REG_W = 8;
	localparam int unsigned FRAME_W = 16;
	localparam logic [4:0] FRAME_PULSES = 5'h10;
	localparam logic [4:0] COUNT_MAX = 5'h1f;
	localparam logic [4:0] ADDR_DONE = 5'h02;
	localparam logic [4:0] CMD_DONE = 5'h08;
	localparam int unsigned CH_LSB = 2;

	// ----------------------------------------------------------------
	// Instruction byte, upper six bits; the low two are ignored
	// ----------------------------------------------------------------
	localparam logic [1:0] ADDR_PREFIX = 2'h2;
	localparam logic [5:0] CMD_WRITE_MODE = 6'h2a;
	localparam logic [5:0] CMD_READ_MODE = 6'h29;
	localparam logic [5:0] CMD_WRITE_SERIAL = 6'h26;
	localparam logic [5:0] CMD_READ_SERIAL = 6'h25;
	localparam logic [5:0] CMD_READ_DIAG = 6'h20;

	// ----------------------------------------------------------------
	// Reset and fill values
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_RESET = 8'hff;
	localparam logic [1:0] UNUSED_FILL = 2'h3;
	localparam logic [7:0] FIRST_REPLY = 8'hff;

endpackage

// [sim/scos_spi_master.sv]
// Controller model that sends serial frames to the output select block.
`timescale 1ns/100ps
`default_nettype none

module scos_spi_master
(
	// Clock used only to place edges.
	input wire logic ref_clk,
	// Serial link.
	output logic chip_select_n,
	output logic serial_clk,
	output logic serial_in,
	input wire logic serial_out,
	input wire logic serial_out_oe
);
	// ----------------------------------------------------------------
	// Frame engine
	// ----------------------------------------------------------------
	logic oe_seen;
	wire logic so_line;

	// A released line shows the inverse of the last bit, so a reply taken
	// while the block is not driving cannot match by luck.
	assign so_line = serial_out_oe ? serial_out : !serial_out;

	// The link clock stands low between frames.
	initial
	begin
		chip_select_n = 1'b1;
		serial_clk = 1'b0;
		serial_in = 1'b0;
		oe_seen = 1'b0;
	end

	// Quarter of the 160 ns link period.
	task automatic qtr();
		repeat (5) @(negedge ref_clk);
	endtask

	// Sends a frame MSB first and gathers the second reply byte.
	task automatic frame(input logic [15:0] tx, input int pulses, output logic [7:0] rx);
		rx = 8'h00;
		oe_seen = 1'b0;
		@(negedge ref_clk);
		chip_select_n = 1'b0;
		for (int k = 0; k < pulses; k++)
		begin
			qtr();
			// Data moves mid-low so it never races the falling edge.
			serial_in = tx[15 - (k % 16)];
			qtr();
			serial_clk = 1'b1;
			qtr();
			qtr();
			oe_seen = oe_seen | serial_out_oe;
			rx = (k >= 8) ? {rx[6:0], so_line} : rx;
			serial_clk = 1'b0;
		end
		qtr();
		chip_select_n = 1'b1;
		serial_in = ~serial_in;
		qtr();
	endtask
endmodule

`default_nettype wire

// [sim/test_scos_select.sv]
// Self-checking bench for the six channel output select block.
`timescale 1ns/100ps
`default_nettype none

module test_scos_select;
	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------
	logic ref_clk;
	logic reset_n;
	logic chip_select_n;
	logic serial_clk;
	logic serial_in;
	logic serial_out;
	logic serial_out_oe;
	logic [5:0] pins;
	logic pol;
	logic [7:0] diag;
	logic [5:0] power_stage_output;
	logic [7:0] rx;
	int error_cnt;
	int check_count;

	scos_select i_dut
	(
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.chip_select_n(chip_select_n),
		.serial_clk(serial_clk),
		.serial_in(serial_in),
		.serial_out(serial_out),
		.serial_out_oe(serial_out_oe),
		.parallel_channel_input(pins),
		.input_polarity_select(pol),
		.stage_diag_status(diag),
		.power_stage_output(power_stage_output)
	);

	scos_spi_master i_master
	(
		.ref_clk(ref_clk),
		.chip_select_n(chip_select_n),
		.serial_clk(serial_clk),
		.serial_in(serial_in),
		.serial_out(serial_out),
		.serial_out_oe(serial_out_oe)
	);

	// System clock, 8 ns period.
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Compares one value and counts it.
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Sends one frame with the command in the upper six bits.
	task automatic xfer(input logic [5:0] cmd, input logic [7:0] data, input int n);
		i_master.frame({cmd, 2'h0, data}, n, rx);
	endtask

	// Reads a register; data bits are junk on purpose.
	task automatic rd(input logic [5:0] cmd, input logic [7:0] exp);
		xfer(cmd, 8'h5a, 16);
		check("reply", exp, rx);
		check("reply oe", 8'h01, {7'h00, i_master.oe_seen});
	endtask

	// Expected stage drive from the register pair and the pins.
	function automatic logic [5:0] drive(input logic [7:0] m, input logic [7:0] s);
		for (int i = 0; i < 6; i++)
			drive[i] = m[i + 2] ? (pins[i] ~^ pol) : ~s[i + 2];
	endfunction

	// Lets pin syncing settle, then compares the stages.
	task automatic check_out(input logic [7:0] m, input logic [7:0] s);
		repeat (6) @(negedge ref_clk);
		check("stages", {2'h0, drive(m, s)}, {2'h0, power_stage_output});
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_values();
		rd(scos_pkg::CMD_READ_MODE, 8'hff);
		rd(scos_pkg::CMD_READ_SERIAL, 8'hff);
		rd(scos_pkg::CMD_READ_DIAG, 8'hff);
	endtask

	task automatic t_parallel();
		pins = 6'h15;
		for (int p = 0; p < 2; p++)
		begin
			pol = p[0];
			check_out(8'hff, 8'hff);
		end
	endtask

	task automatic t_write();
		xfer(scos_pkg::CMD_WRITE_MODE, 8'ha8, 16);
		xfer(scos_pkg::CMD_WRITE_SERIAL, 8'h50, 16);
		rd(scos_pkg::CMD_READ_MODE, 8'hab);
		rd(scos_pkg::CMD_READ_SERIAL, 8'h53);
		pins = 6'h2a;
		check_out(8'hab, 8'h53);
		pol = 1'b0;
		check_out(8'hab, 8'h53);
	endtask

	// Wrong pulse counts, unknown command and a foreign prefix change nothing.
	task automatic t_refused();
		xfer(scos_pkg::CMD_WRITE_MODE, 8'h00, 15);
		xfer(scos_pkg::CMD_WRITE_MODE, 8'h00, 17);
		xfer(6'h2c, 8'h00, 16);
		check("unknown reply", 8'hff, rx);
		i_master.frame(16'h6800, 16, rx);
		check("foreign oe", 8'h00, {7'h00, i_master.oe_seen});
		rd(scos_pkg::CMD_READ_MODE, 8'hab);
		check_out(8'hab, 8'h53);
	endtask

	// A brief channel 4 fault is latched, then cleared by the read.
	task automatic t_diag();
		diag = 8'h7f;
		repeat (10) @(negedge ref_clk);
		diag = 8'hff;
		rd(scos_pkg::CMD_READ_DIAG, 8'h7f);
		rd(scos_pkg::CMD_READ_DIAG, 8'hff);
	endtask

	task automatic t_reset_mid();
		pins = 6'h00;
		reset_n = 1'b0;
		repeat (3) @(negedge ref_clk);
		check("stages in reset", 8'h00, {2'h0, power_stage_output});
		reset_n = 1'b1;
		rd(scos_pkg::CMD_READ_SERIAL, 8'hff);
		check_out(8'hff, 8'hff);
	endtask

	// ----------------------------------------------------------------
	// Sequence, watchdog and verdict
	// ----------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Main sequence; inputs move on the falling edge.
	initial
	begin
		error_cnt = 0;
		check_count = 0;
		reset_n = 1'b0;
		pins = 6'h00;
		pol = 1'b0;
		diag = 8'hff;
		repeat (3) @(negedge ref_clk);
		reset_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		t_reset_values();
		t_parallel();
		t_write();
		t_refused();
		t_diag();
		t_reset_mid();
		close_out();
	end

	// About fifteen frames of some 330 cycles each fit well inside this span.
	initial
	begin
		#100000;
		error_cnt++;
		close_out();
	end
endmodule

`default_nettype wire
